/* logic/clk_dist_pkg.sv */
// shared constants for the clock distribution control block
package clk_dist_pkg;
	localparam int AW = 16;
	localparam int DW = 32;
	localparam int NUM_OUT = 4;
	localparam int NUM_DIV = 4;
	// register indices; byte address is four times the index
	localparam logic [11:0] SYS_IDX = 12'h230;
	localparam logic [11:0] UPD_IDX = 12'h232;
	localparam logic [11:0] OCFG_IDX = 12'h234;
	localparam logic [11:0] DCFG_IDX = 12'h235;
	localparam logic [11:0] STAT_IDX = 12'h236;
	localparam logic [AW-1:0] SYS_ADDR = {2'h0, SYS_IDX, 2'h0};
	localparam logic [AW-1:0] UPD_ADDR = {2'h0, UPD_IDX, 2'h0};
	localparam logic [AW-1:0] OCFG_ADDR = {2'h0, OCFG_IDX, 2'h0};
	localparam logic [AW-1:0] DCFG_ADDR = {2'h0, DCFG_IDX, 2'h0};
	localparam logic [AW-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
	// system register fields
	localparam int SYS_W = 3;
	localparam int SYS_SOFT = 0;
	localparam int SYS_PD_REF = 1;
	localparam int SYS_PD_SYNC = 2;
	localparam logic [SYS_W-1:0] SYS_RST = 3'h0;
	localparam int UPD_BIT = 0;
	// output config fields, one byte per selectable output
	localparam int OC_SE = 0;
	localparam int OC_EN_A = 1;
	localparam int OC_EN_B = 2;
	localparam int OC_INV_A = 3;
	localparam int OC_INV_B = 4;
	localparam int OC_STRIDE = 8;
	localparam int OCFG_W = NUM_OUT * OC_STRIDE;
	localparam logic [OCFG_W-1:0] OCFG_RST = 32'h0;
	localparam logic [NUM_DIV-1:0] DCFG_RST = 4'h0;
	// status fields
	localparam int ST_PIN = 3;
	localparam int ST_HOLD = 4;
	localparam int SYNC_STAGES = 3;
endpackage

/* logic/align_if.sv */
// alignment control signals between register logic and alignment unit
`timescale 1ns/10ps
interface align_if #(parameter int N = 4);
	logic soft_bit;
	logic pin_low;
	logic pwrdn;
	logic [N-1:0] ignore;
	logic [N-1:0] hold;
	logic [N-1:0] fire;
	modport ctrl (output soft_bit, pin_low, pwrdn, ignore, input hold, fire);
	modport unit (input soft_bit, pin_low, pwrdn, ignore, output hold, fire);
endinterface

/* logic/align_unit.sv */
// per divider alignment hold and alignment event generation
`timescale 1ns/10ps
module align_unit #(
	parameter int N = 4
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// alignment controls
	align_if.unit al
);
	logic eff_reg, eff_next;
	logic eff_raw;
	logic [N-1:0] hold_reg, hold_next;
	logic [N-1:0] fire_reg, fire_next;

	always_comb begin
		eff_raw = al.soft_bit | al.pin_low;
		eff_next = ~al.pwrdn & eff_raw;
		for (int i = 0; i < N; i++) begin
			hold_next[i] = eff_next & ~al.ignore[i];
			fire_next[i] = ~al.pwrdn & eff_reg & ~eff_raw & ~al.ignore[i];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			eff_reg <= 1'b0;
			hold_reg <= '0;
			fire_reg <= '0;
		end else begin
			eff_reg <= eff_next;
			hold_reg <= hold_next;
			fire_reg <= fire_next;
		end
	end

	assign al.hold = hold_reg;
	assign al.fire = fire_reg;

	polarity_a: assert property (@(posedge ref_clk) disable iff (rst)
		(!al.pwrdn && (al.soft_bit || al.pin_low)) |=> eff_reg)
		else $error("alignment level not taken from soft bit or pin");
	hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		(al.soft_bit && !al.pwrdn && !al.ignore[0]) |=> hold_reg[0])
		else $error("channel not held while soft bit set");
	release_a: assert property (@(posedge ref_clk) disable iff (rst)
		(eff_reg && !al.soft_bit && !al.pin_low && !al.pwrdn
		&& !al.ignore[0]) |=> fire_reg[0] ##1 !fire_reg[0])
		else $error("release did not give one alignment pulse");
	ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
		al.ignore[0] |=> (!fire_reg[0] && !hold_reg[0]))
		else $error("ignoring divider reacted to alignment");
	pwrdn_a: assert property (@(posedge ref_clk) disable iff (rst)
		al.pwrdn |=> (fire_reg == '0 && !eff_reg))
		else $error("alignment active while powered down");
endmodule

/* logic/clk_dist_ctrl.sv */
// system control, buffered register update and apb slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module clk_dist_ctrl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [clk_dist_pkg::AW-1:0] paddr,
	input wire logic [clk_dist_pkg::DW-1:0] pwdata,
	output logic [clk_dist_pkg::DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from outside
	input wire logic sclk,
	input wire logic sync_n,
	// power down controls
	output logic sync_pwrdn,
	output logic dist_ref_pwrdn,
	// divider alignment
	output logic [clk_dist_pkg::NUM_DIV-1:0] chan_hold,
	output logic [clk_dist_pkg::NUM_DIV-1:0] chan_align,
	// selectable output configuration
	output logic [clk_dist_pkg::NUM_OUT-1:0] se_mode,
	output logic [clk_dist_pkg::NUM_OUT-1:0] out_en_a,
	output logic [clk_dist_pkg::NUM_OUT-1:0] out_en_b,
	output logic [clk_dist_pkg::NUM_OUT-1:0] out_inv_a,
	output logic [clk_dist_pkg::NUM_OUT-1:0] out_inv_b
);
	import clk_dist_pkg::*;

	logic [SYNC_STAGES-1:0] sclk_sync_reg, sclk_sync_next;
	logic [SYNC_STAGES-1:0] syncn_sync_reg, syncn_sync_next;
	logic sclk_lvl_reg, sclk_lvl_next;
	logic syncn_lvl_reg, syncn_lvl_next;
	logic sclk_rise;
	logic [SYS_W-1:0] buf_sys_reg, buf_sys_next;
	logic [SYS_W-1:0] act_sys_reg, act_sys_next;
	logic [OCFG_W-1:0] buf_ocfg_reg, buf_ocfg_next;
	logic [OCFG_W-1:0] act_ocfg_reg, act_ocfg_next;
	logic [NUM_DIV-1:0] buf_dcfg_reg, buf_dcfg_next;
	logic [NUM_DIV-1:0] act_dcfg_reg, act_dcfg_next;
	logic upd_reg, upd_next;
	logic [DW-1:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic setup, wr_en, wr_upd, hit;

	align_if #(.N(NUM_DIV)) al ();

	align_unit #(.N(NUM_DIV)) u_align (
		.ref_clk(ref_clk),
		.rst(rst),
		.al(al)
	);

	assign al.soft_bit = act_sys_reg[SYS_SOFT];
	assign al.pin_low = ~syncn_lvl_reg;
	assign al.pwrdn = act_sys_reg[SYS_PD_SYNC];
	assign al.ignore = act_dcfg_reg;

	// pin synchronisers and settled levels
	always_comb begin
		sclk_sync_next = {sclk_sync_reg[SYNC_STAGES-2:0], sclk};
		syncn_sync_next = {syncn_sync_reg[SYNC_STAGES-2:0], sync_n};
		sclk_lvl_next = sclk_lvl_reg;
		syncn_lvl_next = syncn_lvl_reg;
		if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
			sclk_lvl_next = sclk_sync_reg[2];
		end
		if (syncn_sync_reg[1] == syncn_sync_reg[2]) begin
			syncn_lvl_next = syncn_sync_reg[2];
		end
		sclk_rise = sclk_lvl_next & ~sclk_lvl_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclk_sync_reg <= '0;
			syncn_sync_reg <= '1;
			sclk_lvl_reg <= 1'b0;
			syncn_lvl_reg <= 1'b1;
		end else begin
			sclk_sync_reg <= sclk_sync_next;
			syncn_sync_reg <= syncn_sync_next;
			sclk_lvl_reg <= sclk_lvl_next;
			syncn_lvl_reg <= syncn_lvl_next;
		end
	end

	// register file, update and bus answer
	always_comb begin
		setup = psel & ~penable;
		wr_en = psel & penable & pready_reg & pwrite;
		wr_upd = wr_en && paddr == UPD_ADDR && pwdata[UPD_BIT];
		buf_sys_next = buf_sys_reg;
		buf_ocfg_next = buf_ocfg_reg;
		buf_dcfg_next = buf_dcfg_reg;
		act_sys_next = act_sys_reg;
		act_ocfg_next = act_ocfg_reg;
		act_dcfg_next = act_dcfg_reg;
		upd_next = upd_reg;
		if (upd_reg && sclk_rise) begin
			act_sys_next = buf_sys_reg;
			act_ocfg_next = buf_ocfg_reg;
			act_dcfg_next = buf_dcfg_reg;
			upd_next = 1'b0;
		end
		if (wr_upd) begin
			upd_next = 1'b1;
		end
		if (wr_en && paddr == SYS_ADDR) begin
			buf_sys_next = pwdata[SYS_W-1:0];
		end
		if (wr_en && paddr == OCFG_ADDR) begin
			buf_ocfg_next = pwdata[OCFG_W-1:0];
		end
		if (wr_en && paddr == DCFG_ADDR) begin
			buf_dcfg_next = pwdata[NUM_DIV-1:0];
		end
		hit = 1'b1;
		prdata_next = '0;
		case (paddr)
			SYS_ADDR: prdata_next[SYS_W-1:0] = buf_sys_reg;
			UPD_ADDR: prdata_next[UPD_BIT] = upd_reg;
			OCFG_ADDR: prdata_next[OCFG_W-1:0] = buf_ocfg_reg;
			DCFG_ADDR: prdata_next[NUM_DIV-1:0] = buf_dcfg_reg;
			STAT_ADDR: begin
				prdata_next[SYS_W-1:0] = act_sys_reg;
				prdata_next[ST_PIN] = syncn_lvl_reg;
				prdata_next[ST_HOLD] = |al.hold;
			end
			default: hit = 1'b0;
		endcase
		if (!setup) begin
			prdata_next = prdata_reg;
		end
		pready_next = setup;
		pslverr_next = setup ? ~hit : pslverr_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			buf_sys_reg <= SYS_RST;
			act_sys_reg <= SYS_RST;
			buf_ocfg_reg <= OCFG_RST;
			act_ocfg_reg <= OCFG_RST;
			buf_dcfg_reg <= DCFG_RST;
			act_dcfg_reg <= DCFG_RST;
			upd_reg <= 1'b0;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			buf_sys_reg <= buf_sys_next;
			act_sys_reg <= act_sys_next;
			buf_ocfg_reg <= buf_ocfg_next;
			act_ocfg_reg <= act_ocfg_next;
			buf_dcfg_reg <= buf_dcfg_next;
			act_dcfg_reg <= act_dcfg_next;
			upd_reg <= upd_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign sync_pwrdn = act_sys_reg[SYS_PD_SYNC];
	assign dist_ref_pwrdn = act_sys_reg[SYS_PD_REF];
	assign chan_hold = al.hold;
	assign chan_align = al.fire;

	// each selectable output splits into two single ended halves
	for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
		assign se_mode[i] = act_ocfg_reg[i*OC_STRIDE+OC_SE];
		assign out_en_a[i] = act_ocfg_reg[i*OC_STRIDE+OC_EN_A];
		assign out_en_b[i] = act_ocfg_reg[i*OC_STRIDE+OC_EN_B];
		assign out_inv_a[i] = act_ocfg_reg[i*OC_STRIDE+OC_INV_A];
		assign out_inv_b[i] = act_ocfg_reg[i*OC_STRIDE+OC_INV_B];
	end

	upd_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
		(upd_reg && sclk_rise) |=> act_sys_reg == $past(buf_sys_reg))
		else $error("buffer not copied on serial clock rise");
	upd_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
		(upd_reg && !sclk_rise) |=> (upd_reg && $stable(act_sys_reg)))
		else $error("update acted without serial clock rise");
	upd_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		(upd_reg && sclk_rise && !wr_upd) |=> !upd_reg)
		else $error("update bit did not clear itself");
	sync_pd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(upd_reg && sclk_rise && buf_sys_reg[SYS_PD_SYNC]) |=> sync_pwrdn)
		else $error("alignment power down not applied");
	ref_pd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(upd_reg && sclk_rise && !buf_sys_reg[SYS_PD_REF]) |=> !dist_ref_pwrdn)
		else $error("reference power down not released");
	out_split_a: assert property (@(posedge ref_clk) disable iff (rst)
		(upd_reg && sclk_rise) |=> (out_en_b[1] == $past(buf_ocfg_reg[
		OC_STRIDE+OC_EN_B]) && out_inv_a[1] == $past(buf_ocfg_reg[
		OC_STRIDE+OC_INV_A])))
		else $error("output half controls not taken from config");
endmodule

/* sim/host_link_model.sv */
// serial host side model: serial clock frames and alignment pin
`timescale 1ns/10ps
module host_link_model (
	// pins toward the block
	output logic sclk,
	output logic sync_n
);
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
	end
	// one frame of n serial clocks, 160 ns period, idle low after
	task automatic burst(input int n);
		#5;
		repeat (n) begin
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
	endtask
	// drive the pin low or drive it high again
	task automatic pin(input logic low);
		sync_n <= ~low;
	endtask
endmodule

/* sim/clk_dist_ctrl_bench.sv */
// self-checking bench for the clock distribution control block
`timescale 1ns/10ps
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("[ERR] %0t got %h expected %h", $time, got, exp); \
	end \
end
module clk_dist_ctrl_bench;
	import clk_dist_pkg::*;
	logic ref_clk = 1'b0;
	logic rst, psel, penable, pwrite;
	logic [AW-1:0] paddr;
	logic [DW-1:0] pwdata;
	logic [DW-1:0] prdata;
	logic [DW-1:0] rd;
	logic pready, pslverr, err, sclk, sync_n, sync_pwrdn, dist_ref_pwrdn;
	logic [NUM_DIV-1:0] chan_hold, chan_align, acc;
	logic [NUM_OUT-1:0] se_mode, out_en_a, out_en_b, out_inv_a, out_inv_b;
	int bad_count = 0;
	int check_count = 0;
	always #10 ref_clk = ~ref_clk;
	host_link_model host (.sclk(sclk), .sync_n(sync_n));
	clk_dist_ctrl dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk(sclk), .sync_n(sync_n),
		.sync_pwrdn(sync_pwrdn), .dist_ref_pwrdn(dist_ref_pwrdn),
		.chan_hold(chan_hold), .chan_align(chan_align),
		.se_mode(se_mode), .out_en_a(out_en_a), .out_en_b(out_en_b),
		.out_inv_a(out_inv_a), .out_inv_b(out_inv_b));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [AW-1:0] a,
		input logic [DW-1:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (n > 20) begin
				bad_count++;
				$display("[ERR] %0t no ready", $time);
				stop_test();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	// collect alignment pulses over a window
	task automatic watch();
		acc = '0;
		repeat (20) begin
			@(posedge ref_clk);
			acc = acc | chan_align;
		end
	endtask
	task automatic update();
		apb(1'b1, UPD_ADDR, 32'h1);
		host.burst(1);
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		`CHK(sync_pwrdn, 1'b0)
		`CHK(dist_ref_pwrdn, 1'b0)
		apb(1'b0, SYS_ADDR, 32'h0);
		`CHK(rd[2:0], SYS_RST)
		apb(1'b0, 16'h0ffc, 32'h0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		$display("test reset done");
	endtask
	task automatic t_power();
		apb(1'b1, SYS_ADDR, 32'h6);
		apb(1'b0, UPD_ADDR, 32'h0);
		`CHK(sync_pwrdn, 1'b0)
		update();
		`CHK(sync_pwrdn, 1'b1)
		`CHK(dist_ref_pwrdn, 1'b1)
		apb(1'b0, UPD_ADDR, 32'h0);
		`CHK(rd[0], 1'b0)
		apb(1'b1, SYS_ADDR, 32'h4);
		update();
		`CHK(dist_ref_pwrdn, 1'b0)
		host.pin(1'b1);
		repeat (8) @(posedge ref_clk);
		`CHK(chan_hold, 4'h0)
		fork host.pin(1'b0); watch(); join
		`CHK(acc, 4'h0)
		apb(1'b1, SYS_ADDR, 32'h0);
		update();
		$display("test power done");
	endtask
	task automatic t_pin();
		host.pin(1'b1);
		repeat (8) @(posedge ref_clk);
		`CHK(chan_hold, 4'hf)
		apb(1'b0, STAT_ADDR, 32'h0);
		`CHK(rd, 32'h10)
		fork host.pin(1'b0); watch(); join
		`CHK(acc, 4'hf)
		$display("test pin done");
	endtask
	task automatic t_soft();
		apb(1'b1, DCFG_ADDR, 32'h5);
		apb(1'b1, SYS_ADDR, 32'h1);
		update();
		`CHK(chan_hold, 4'ha)
		apb(1'b1, SYS_ADDR, 32'h0);
		apb(1'b1, UPD_ADDR, 32'h1);
		fork host.burst(1); watch(); join
		`CHK(acc, 4'ha)
		`CHK(chan_hold, 4'h0)
		$display("test soft done");
	endtask
	task automatic t_out();
		apb(1'b1, OCFG_ADDR, 32'h1f0b1500);
		`CHK(se_mode, 4'h0)
		update();
		`CHK(se_mode, 4'he)
		`CHK(out_en_a, 4'hc)
		`CHK(out_en_b, 4'ha)
		`CHK(out_inv_a, 4'hc)
		`CHK(out_inv_b, 4'ha)
		$display("test out done");
	endtask
	initial begin
		rst <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= '0;
		pwdata <= '0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_power();
		t_pin();
		t_soft();
		t_out();
		stop_test();
	end
endmodule
